// File: hw/qmec_pin_if.sv
`timescale 1ns/1ps
interface qmec_pin_if;
  import qmec_pkg::*;
  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  logic sel_start;
  logic sel_end;
  qmec_nib_t din;

  modport front (output sclk_rise, output sclk_fall, output sel, output sel_start,
    output sel_end, output din);
  modport core (input sclk_rise, input sclk_fall, input sel, input sel_start,
    input sel_end, input din);
endinterface : qmec_pin_if

// File: hw/qmec_pin_sync.sv
`timescale 1ns/1ps
module qmec_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire qmec_pkg::qmec_nib_t io_i,
  qmec_pin_if.front pins
);
  import qmec_pkg::*;

  localparam int unsigned NPIN = 6;
  logic [NPIN-1:0] raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic sclk_d_r;
  logic sel_d_r;

  assign raw = {sclk_i, cs_n_i, io_i};

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers, chip select parks deselected
  generate
    for (genvar g = 0; g < NPIN; g++)
    begin : g_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_r[g] <= PIN_SYNC_RST[g];
          s2_r[g] <= PIN_SYNC_RST[g];
        end
        else
        begin
          s1_r[g] <= raw[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate

  // Edge history, taken only from the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= s2_r[5];
      sel_d_r <= ~s2_r[4];
    end
  end

  // Data is taken from the same stage as the clock, so it is aligned
  assign pins.sclk_rise = s2_r[5] & ~sclk_d_r;
  assign pins.sclk_fall = ~s2_r[5] & sclk_d_r;
  assign pins.sel = ~s2_r[4];
  assign pins.sel_start = ~s2_r[4] & ~sel_d_r;
  assign pins.sel_end = s2_r[4] & sel_d_r;
  assign pins.din = s2_r[3:0];

endmodule : qmec_pin_sync

// File: hw/qmec_pkg.sv
package qmec_pkg;

  // Pin bundles
  typedef logic [3:0] qmec_nib_t;
  typedef logic [7:0] qmec_byte_t;

  // Serial instructions
  localparam qmec_byte_t CMD_READ_STATUS1 = 8'h05;
  localparam qmec_byte_t CMD_READ_STATUS2 = 8'h35;
  localparam qmec_byte_t CMD_WRITE_STATUS = 8'h01;
  localparam qmec_byte_t CMD_ENTER_FOUR_WIRE = 8'h38;
  localparam qmec_byte_t CMD_EXIT_FOUR_WIRE = 8'hff;
  localparam qmec_byte_t CMD_RESET_ENABLE = 8'h66;
  localparam qmec_byte_t CMD_RESET = 8'h99;
  localparam qmec_byte_t CMD_QUAD_IO_READ = 8'heb;
  localparam qmec_byte_t CMD_READ_DISCOVERY = 8'h5a;

  // Status register layout
  localparam int unsigned QE_BIT = 1;
  localparam qmec_byte_t BUSY_MASK = 8'h01;
  localparam qmec_byte_t SR1_WR_MASK = 8'hfc;
  localparam qmec_byte_t SR1_RST = 8'h00;
  localparam qmec_byte_t SR2_RST = 8'h00;
  localparam logic [1:0] WR_BYTES = 2'h2;

  // Continuous read mode bits
  localparam qmec_nib_t MODE_STAY_NIB = 4'ha;
  localparam qmec_byte_t MODE_EXIT = 8'h00;
  localparam qmec_nib_t EXIT_NIB = 4'hf;
  localparam logic [3:0] EXIT_CLOCKS = 4'h8;

  // Frame geometry, in bits or clocks
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] QREAD_DUMMY_CLKS = 5'h04;
  localparam logic [4:0] DISC_DUMMY_CLKS = 5'h08;
  localparam logic [4:0] NO_PHASE_END = 5'h1f;

  // Discovery table contents
  localparam logic [23:0] DISC_REL_ADDR = 24'h00006c;
  localparam qmec_byte_t DISC_REL_VALUE = 8'he8;
  localparam qmec_byte_t DISC_BLANK = 8'hff;

  // Output enables
  localparam qmec_nib_t OE_QUAD = 4'hf;
  localparam qmec_nib_t OE_SINGLE = 4'h2;
  localparam qmec_nib_t OE_OFF = 4'h0;

  // Synchroniser reset levels: sclk, cs_n, io3..io0
  localparam logic [5:0] PIN_SYNC_RST = 6'h10;

  // Wishbone register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam logic [3:0] REG_SR1 = 4'h8;
  localparam logic [3:0] REG_SR2 = 4'hc;

endpackage : qmec_pkg

// File: hw/qmec_quad_mode_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] The quad line enable flag lives in bit 1 of the second status register.
// [RULE2] Instruction 05h returns the first status register, 35h the second one.
// [RULE3] Instruction 01h with two bytes sets the flag from bit 1 of the second byte.
// [RULE4] While the flag is set the hold and write-protect pin functions are off.
// [RULE5] The host sets the flag before entering continuous quad read with mode bits A5h.
// [RULE6] Mode bits with upper nibble A keep the continuous quad read going.
// [RULE7] Mode bits 00h end continuous quad read once the current read finishes.
// [RULE8] Fh on all four lines for 8 clocks ends continuous quad read before the next read.
// [RULE9] Continuous quad read omits the instruction and moves address and data on four lines.
// [RULE10] With the flag set, instruction 38h enters four-wire command mode.
// [RULE11] Instruction FFh in four-wire command mode returns to single-wire commands.
// [RULE12] Reset-enable 66h then reset 99h also leaves four-wire command mode.
// [RULE13] The discovery table returns E8h at parameter-relative byte 6Ch.
// [RULE14] Input is taken on the rising serial clock edge, output changes on the falling one.
// [RULE15] Bit 0 of the first status register is busy, 1 busy and 0 ready.
// [RULE16] In four-wire command mode every phase moves four bits per clock.
module qmec_quad_mode_ctrl #(
  parameter logic [23:0] DISC_PARAM_BASE = 24'h000030
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire qmec_pkg::qmec_nib_t io_i,
  output qmec_pkg::qmec_nib_t io_o,
  output qmec_pkg::qmec_nib_t io_oe_o,
  output logic hold_func_en_o,
  output logic wp_func_en_o
);
  import qmec_pkg::*;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_OUT = 8'h20,
    ST_IN = 8'h40,
    ST_SKIP = 8'h80
  } qmec_state_e;

  // Clocks a phase of the given bit count takes on one or four lines
  function automatic logic [4:0] clocks_for(input logic [4:0] bits, input logic q);
    return q ? {2'b00, bits[4:2]} : bits;
  endfunction : clocks_for

  // [RULE13] Discovery byte lookup
  // Byte presented for a read instruction at a given address
  function automatic qmec_byte_t out_byte(input qmec_byte_t cmd, input logic [23:0] adr,
                                          input qmec_byte_t s1, input qmec_byte_t s2);
    logic hit;
    hit = (adr == DISC_PARAM_BASE + DISC_REL_ADDR);
    case (cmd)
      CMD_READ_STATUS1: return s1;
      CMD_READ_STATUS2: return s2;
      CMD_READ_DISCOVERY: return hit ? DISC_REL_VALUE : DISC_BLANK;
      default: return adr[7:0];
    endcase
  endfunction : out_byte

  qmec_state_e st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic quad_r, quad_nxt;
  qmec_byte_t cmd_r, cmd_nxt;
  logic [23:0] addr_r, addr_nxt;
  qmec_byte_t tx_r, tx_nxt;
  logic [4:0] txcnt_r, txcnt_nxt;
  qmec_nib_t dout_r, dout_nxt;
  qmec_nib_t oe_r, oe_nxt;
  logic cont_r, cont_nxt;
  logic req_r, req_nxt;
  logic four_r, four_nxt;
  logic rsten_r, rsten_nxt;
  logic [3:0] ffcnt_r, ffcnt_nxt;
  logic ffrun_r, ffrun_nxt;
  logic [1:0] wcnt_r, wcnt_nxt;
  logic [15:0] wr_r, wr_nxt;
  qmec_byte_t sr1_r, sr1_nxt;
  qmec_byte_t sr2_r, sr2_nxt;
  logic hold_r;
  logic busy;
  qmec_byte_t sr1_view;
  logic rise;
  logic fall;
  logic [23:0] rx_word;
  qmec_byte_t rx_byte;
  logic [4:0] cnt_inc;
  logic [4:0] phase_len;
  logic done;
  logic commit;
  logic [4:0] out_len;
  logic out_last;

  qmec_pin_if pins ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin front end and register slave
  qmec_pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .io_i(io_i),
    .pins(pins.front)
  );

  qmec_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    // [RULE1] Flag from bit 1
    .qe_i(sr2_r[QE_BIT]),
    .cont_i(cont_r),
    .four_i(four_r),
    .sr1_i(sr1_view),
    .sr2_i(sr2_r),
    .busy_o(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // [RULE14] Edges gated by select
  assign rise = pins.sclk_rise & pins.sel;
  assign fall = pins.sclk_fall & pins.sel;
  // [RULE16] Width follows the phase: one line or four
  assign rx_word = quad_r ? {sh_r[19:0], pins.din} : {sh_r[22:0], pins.din[0]};
  assign rx_byte = rx_word[7:0];
  assign cnt_inc = cnt_r + 5'h01;
  // [RULE15] Busy level shown in bit 0
  assign sr1_view = (sr1_r & ~BUSY_MASK) | (busy ? BUSY_MASK : 8'h00);
  assign commit = pins.sel_end & (wcnt_r == WR_BYTES);
  assign out_len = clocks_for(BYTE_BITS, quad_r);
  assign out_last = (txcnt_r == out_len - 5'h01);

  // Phase length per state; skip never ends on its own
  assign phase_len = (st_r == ST_CMD) ? clocks_for(BYTE_BITS, quad_r) :
                     (st_r == ST_ADDR) ? clocks_for(ADDR_BITS, quad_r) :
                     (st_r == ST_MODE) ? clocks_for(BYTE_BITS, 1'b1) :
                     (st_r == ST_DUMMY) ? ((cmd_r == CMD_QUAD_IO_READ) ? QREAD_DUMMY_CLKS :
                                           DISC_DUMMY_CLKS) :
                     (st_r == ST_IN) ? clocks_for(BYTE_BITS, quad_r) : NO_PHASE_END;
  assign done = rise & (cnt_inc == phase_len);

  ////////////////////////////////////////////////////////////////////////////
  // Frame engine: select edges first, then serial clock edges
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    quad_nxt = quad_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    txcnt_nxt = txcnt_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    cont_nxt = cont_r;
    req_nxt = req_r;
    four_nxt = four_r;
    rsten_nxt = rsten_r;
    ffcnt_nxt = ffcnt_r;
    ffrun_nxt = ffrun_r;
    wcnt_nxt = wcnt_r;
    wr_nxt = wr_r;
    sr1_nxt = sr1_r;
    sr2_nxt = sr2_r;
    if (pins.sel_start)
    begin
      // [RULE9] Continuous read starts straight at the address
      st_nxt = cont_r ? ST_ADDR : ST_CMD;
      cmd_nxt = cont_r ? CMD_QUAD_IO_READ : cmd_r;
      // [RULE16] Four-wire mode widens the instruction too
      quad_nxt = cont_r | four_r;
      cnt_nxt = 5'h00;
      ffcnt_nxt = 4'h0;
      ffrun_nxt = cont_r;
      wcnt_nxt = 2'h0;
      req_nxt = cont_r;
      oe_nxt = OE_OFF;
    end
    else if (pins.sel_end)
    begin
      st_nxt = ST_IDLE;
      oe_nxt = OE_OFF;
      // [RULE7] Mode change takes effect only as the read ends
      cont_nxt = req_r;
      if (commit)
      begin
        // [RULE3] Second byte carries the flag
        sr1_nxt = (wr_r[15:8] & SR1_WR_MASK) | (sr1_r & ~SR1_WR_MASK);
        sr2_nxt = wr_r[7:0];
      end
    end
    else if (rise)
    begin
      sh_nxt = rx_word;
      cnt_nxt = done ? 5'h00 : cnt_inc;
      if (done)
      begin
        unique case (st_r)
          ST_CMD:
          begin
            cmd_nxt = rx_byte;
            rsten_nxt = 1'b0;
            st_nxt = ST_SKIP;
            case (rx_byte)
              // [RULE2] Status reads pick the register by instruction
              CMD_READ_STATUS1, CMD_READ_STATUS2:
              begin
                st_nxt = ST_OUT;
                tx_nxt = out_byte(rx_byte, addr_r, sr1_view, sr2_r);
                txcnt_nxt = 5'h00;
              end
              CMD_WRITE_STATUS: st_nxt = ST_IN;
              // [RULE10] Entry only with the flag already set
              CMD_ENTER_FOUR_WIRE: four_nxt = four_r | sr2_r[QE_BIT];
              // [RULE11] Back to single-wire commands
              CMD_EXIT_FOUR_WIRE: four_nxt = 1'b0;
              CMD_RESET_ENABLE: rsten_nxt = 1'b1;
              // [RULE12] Reset only counts right after reset-enable
              CMD_RESET:
              begin
                four_nxt = four_r & ~rsten_r;
                req_nxt = req_r & ~rsten_r;
              end
              // [RULE5] Quad read ignored while the flag is clear
              CMD_QUAD_IO_READ:
              begin
                st_nxt = sr2_r[QE_BIT] ? ST_ADDR : ST_SKIP;
                quad_nxt = 1'b1;
              end
              CMD_READ_DISCOVERY: st_nxt = ST_ADDR;
              default: st_nxt = ST_SKIP;
            endcase
          end
          ST_ADDR:
          begin
            addr_nxt = rx_word;
            st_nxt = (cmd_r == CMD_QUAD_IO_READ) ? ST_MODE : ST_DUMMY;
          end
          ST_MODE:
          begin
            // [RULE6] Any A nibble stays, 00h and others leave
            req_nxt = (rx_word[7:4] == MODE_STAY_NIB);
            st_nxt = ST_DUMMY;
          end
          ST_DUMMY:
          begin
            st_nxt = ST_OUT;
            tx_nxt = out_byte(cmd_r, addr_r, sr1_view, sr2_r);
            txcnt_nxt = 5'h00;
          end
          ST_IN:
          begin
            wcnt_nxt = wcnt_r + 2'h1;
            wr_nxt = {wr_r[7:0], rx_byte};
            st_nxt = (wcnt_r == WR_BYTES - 2'h1) ? ST_SKIP : ST_IN;
          end
          ST_IDLE, ST_OUT, ST_SKIP: ;
        endcase
      end
      // [RULE8] Fh for 8 clocks from frame start cancels continuous read
      if (ffrun_r)
      begin
        ffrun_nxt = (pins.din == EXIT_NIB) && (ffcnt_r != EXIT_CLOCKS - 4'h1);
        ffcnt_nxt = ffcnt_r + 4'h1;
        if ((pins.din == EXIT_NIB) && (ffcnt_r == EXIT_CLOCKS - 4'h1))
        begin
          req_nxt = 1'b0;
          st_nxt = ST_SKIP;
        end
      end
    end
    else if (fall && (st_r == ST_OUT))
    begin
      // [RULE14] New output bits only after a falling edge
      dout_nxt = quad_r ? tx_r[7:4] : {2'b00, tx_r[7], 1'b0};
      oe_nxt = quad_r ? OE_QUAD : OE_SINGLE;
      txcnt_nxt = out_last ? 5'h00 : txcnt_r + 5'h01;
      addr_nxt = out_last ? addr_r + 24'h000001 : addr_r;
      tx_nxt = out_last ? out_byte(cmd_r, addr_r + 24'h000001, sr1_view, sr2_r) :
               (quad_r ? {tx_r[3:0], 4'h0} : {tx_r[6:0], 1'b0});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      quad_r <= 1'b0;
      cmd_r <= 8'h00;
      addr_r <= 24'h000000;
      tx_r <= 8'h00;
      txcnt_r <= 5'h00;
      dout_r <= 4'h0;
      oe_r <= OE_OFF;
      cont_r <= 1'b0;
      req_r <= 1'b0;
      four_r <= 1'b0;
      rsten_r <= 1'b0;
      ffcnt_r <= 4'h0;
      ffrun_r <= 1'b0;
      wcnt_r <= 2'h0;
      wr_r <= 16'h0000;
      sr1_r <= SR1_RST;
      sr2_r <= SR2_RST;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      quad_r <= quad_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      tx_r <= tx_nxt;
      txcnt_r <= txcnt_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      cont_r <= cont_nxt;
      req_r <= req_nxt;
      four_r <= four_nxt;
      rsten_r <= rsten_nxt;
      ffcnt_r <= ffcnt_nxt;
      ffrun_r <= ffrun_nxt;
      wcnt_r <= wcnt_nxt;
      wr_r <= wr_nxt;
      sr1_r <= sr1_nxt;
      sr2_r <= sr2_nxt;
    end
  end

  // [RULE4] Flag set turns hold and write-protect into data lines
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_r <= 1'b1;
    else
      hold_r <= ~sr2_r[QE_BIT];
  end

  assign io_o = dout_r;
  assign io_oe_o = oe_r;
  assign hold_func_en_o = hold_r;
  assign wp_func_en_o = hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sr2_qe_read: assert property ( // [RULE1]
    (done && st_r == ST_CMD && rx_byte == CMD_READ_STATUS2)
    |=> st_r == ST_OUT && tx_r[QE_BIT] == $past(sr2_r[QE_BIT])) else $error("flag not in bit 1");
  a_sr1_read_out: assert property ( // [RULE2]
    (done && st_r == ST_CMD && rx_byte == CMD_READ_STATUS1)
    |=> st_r == ST_OUT && tx_r == $past(sr1_view)) else $error("status 1 read wrong");
  a_qe_write_sets: assert property ( // [RULE3]
    commit |=> sr2_r[QE_BIT] == $past(wr_r[QE_BIT])) else $error("status write lost flag");
  a_pins_as_data: assert property ( // [RULE4]
    $changed(sr2_r[QE_BIT]) |=> hold_func_en_o == !$past(sr2_r[QE_BIT]) && wp_func_en_o == hold_func_en_o)
    else $error("pin function not following flag");
  a_mode_nibble_stay: assert property ( // [RULE6]
    (done && st_r == ST_MODE && rx_word[7:4] == MODE_STAY_NIB) |=> req_r)
    else $error("A nibble did not keep mode");
  a_mode_exit_end: assert property ( // [RULE7]
    (done && st_r == ST_MODE && rx_byte == MODE_EXIT) |=> !req_r && cont_r == $past(cont_r))
    else $error("00h exit handled wrong");
  a_ff_exit: assert property ( // [RULE8]
    (rise && ffrun_r && pins.din == EXIT_NIB && ffcnt_r == EXIT_CLOCKS - 4'h1)
    |=> !req_r && st_r == ST_SKIP) else $error("Fh exit missed");
  a_cont_no_cmd: assert property ( // [RULE9]
    (pins.sel_start && cont_r) |=> st_r == ST_ADDR && quad_r && cmd_r == CMD_QUAD_IO_READ)
    else $error("continuous read expected address");
  a_enter_four: assert property ( // [RULE10]
    (done && st_r == ST_CMD && rx_byte == CMD_ENTER_FOUR_WIRE)
    |=> four_r == $past(four_r | sr2_r[QE_BIT])) else $error("four-wire entry wrong");
  a_exit_four: assert property ( // [RULE11]
    (done && st_r == ST_CMD && rx_byte == CMD_EXIT_FOUR_WIRE) |=> !four_r)
    else $error("FFh did not leave four-wire");
  a_soft_reset: assert property ( // [RULE12]
    (done && st_r == ST_CMD && rx_byte == CMD_RESET && rsten_r) |=> !four_r && !req_r)
    else $error("soft reset did not leave modes");
  a_disc_byte: assert property ( // [RULE13]
    (done && st_r == ST_DUMMY && cmd_r == CMD_READ_DISCOVERY
     && addr_r == DISC_PARAM_BASE + DISC_REL_ADDR) |=> tx_r == DISC_REL_VALUE)
    else $error("discovery byte wrong");
  a_out_on_fall: assert property ( // [RULE14]
    $changed(io_o) |-> $past(pins.sclk_fall)) else $error("output moved off a falling edge");
  a_four_width: assert property ( // [RULE16]
    (pins.sel_start && four_r) |=> quad_r) else $error("four-wire frame not quad");

  c_cont_entry: cover property (done && st_r == ST_MODE && rx_byte == 8'ha5 ##[1:300] cont_r);
  c_four_entry: cover property ($rose(four_r));
  c_ff_exit: cover property (rise && ffrun_r && ffcnt_r == EXIT_CLOCKS - 4'h1);

endmodule : qmec_quad_mode_ctrl

// File: hw/qmec_wb_regs.sv
`timescale 1ns/1ps
module qmec_wb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic qe_i,
  input wire logic cont_i,
  input wire logic four_i,
  input wire qmec_pkg::qmec_byte_t sr1_i,
  input wire qmec_pkg::qmec_byte_t sr2_i,
  output logic busy_o
);
  import qmec_pkg::*;

  logic ack_r;
  logic busy_r;
  logic [31:0] dat_r;
  logic take;
  logic wr_ctrl;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Decode; one ack per request, unmapped reads give zero
  assign take = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_ctrl = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL);
  assign rd_word = (wb_adr_i == REG_CTRL) ? {31'h0, busy_r} :
                   (wb_adr_i == REG_STATE) ? {29'h0, four_i, cont_i, qe_i} :
                   (wb_adr_i == REG_SR1) ? {24'h0, sr1_i} :
                   (wb_adr_i == REG_SR2) ? {24'h0, sr2_i} : 32'h0;

  // Ack and read data registered together
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end
    else
    begin
      ack_r <= take;
      dat_r <= take ? rd_word : dat_r;
    end
  end

  // Software-driven array busy level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      busy_r <= 1'b0;
    else if (wr_ctrl)
      busy_r <= wb_dat_i[0];
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign busy_o = busy_r;

endmodule : qmec_wb_regs

// File: verification/qmec_host_model.sv
`timescale 1ns/1ps
module qmec_host_model
  import qmec_pkg::*;
(
  output logic sclk_o,
  output logic cs_n_o,
  output qmec_nib_t io_o,
  input wire qmec_nib_t dev_io_i,
  input wire qmec_nib_t dev_oe_i
);
  qmec_nib_t drv_r;
  logic own_r;
  logic cpol_r;
  // Undriven lines show the inverse of the last value, never a stale copy
  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & (own_r ? drv_r : ~drv_r));
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    drv_r = 4'h0;
    own_r = 1'b0;
    cpol_r = 1'b0;
  end
  task automatic mode(input logic m);
    cpol_r = m;
  endtask : mode
  // Clock parks at the mode's idle level, only while deselected
  task automatic frame(input logic open);
    if (open)
      sclk_o = cpol_r;
    #32 cs_n_o = !open;
    #32;
  endtask : frame
  // drive after fall, sample at rise; mode 3 ends high
  task automatic cyc(input qmec_nib_t d, input logic own, output qmec_nib_t q);
    if (sclk_o)
      #32 sclk_o = 1'b0;
    drv_r = d;
    own_r = own;
    #32 sclk_o = 1'b1;
    q = io_o;
    if (!cpol_r)
      #32 sclk_o = 1'b0;
  endtask : cyc
  task automatic put(input qmec_byte_t b, input logic quad);
    qmec_nib_t q;
    if (quad)
    begin
      cyc(b[7:4], 1'b1, q);
      cyc(b[3:0], 1'b1, q);
    end
    else
      for (int i = 7; i >= 0; i--) cyc({3'h0, b[i]}, 1'b1, q);
  endtask : put
  task automatic get(output qmec_byte_t b, input logic quad);
    qmec_nib_t q;
    b = 8'h00;
    if (quad)
      for (int i = 1; i >= 0; i--)
      begin
        cyc(4'h0, 1'b0, q);
        b[i*4 +: 4] = q;
      end
    else
      for (int i = 7; i >= 0; i--)
      begin
        cyc(4'h0, 1'b0, q);
        b[i] = q[1];
      end
  endtask : get
  task automatic idle(input int n, input qmec_nib_t d);
    qmec_nib_t q;
    repeat (n) cyc(d, 1'b1, q);
  endtask : idle
endmodule : qmec_host_model

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import qmec_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'hf, bsel = 4'hf;
  logic [31:0] dat = 32'h0, dat_o, r;
  logic ack, sclk, cs_n, hold_en, wp_en;
  qmec_nib_t io_in, io_out, io_oe;
  qmec_byte_t b;
  int error_cnt = 0, compares = 0, tick = 0;
  always #2.5 clk_i = ~clk_i;
  qmec_quad_mode_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_in), .io_o(io_out),
    .io_oe_o(io_oe), .hold_func_en_o(hold_en), .wp_func_en_o(wp_en));
  qmec_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_in), .dev_io_i(io_out),
    .dev_oe_i(io_oe));
  task automatic test_done;
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= bsel;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic state(input logic [31:0] e);
    wb(1'b0, REG_STATE, 32'h0);
    chk("state", e, r);
  endtask : state
  task automatic scmd(input qmec_byte_t c, input logic q, input logic rd, input qmec_byte_t e);
    host.frame(1'b1);
    host.put(c, q);
    if (rd)
    begin
      host.get(b, q);
      chk("serial read", {24'h0, e}, {24'h0, b});
    end
    host.frame(1'b0);
  endtask : scmd
  task automatic wrsr(input qmec_byte_t s1, input qmec_byte_t s2);
    host.frame(1'b1);
    host.put(CMD_WRITE_STATUS, 1'b0);
    host.put(s1, 1'b0);
    host.put(s2, 1'b0);
    host.frame(1'b0);
  endtask : wrsr
  task automatic qread(input logic cmd, input qmec_byte_t a, input qmec_byte_t m);
    host.frame(1'b1);
    if (cmd)
      host.put(CMD_QUAD_IO_READ, 1'b0);
    host.put(8'h00, 1'b1);
    host.put(8'h00, 1'b1);
    host.put(a, 1'b1);
    host.put(m, 1'b1);
    host.idle(4, 4'h0);
    host.get(b, 1'b1);
    chk("quad data", {24'h0, a}, {24'h0, b});
    host.frame(1'b0);
  endtask : qread
  always @(posedge clk_i)
  begin
    tick++;
    if (tick == 40000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    state(32'h0);
    chk("hold", 32'h1, {31'h0, hold_en & wp_en});
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, r);
    // Busy write with its byte lane off must be ignored
    bsel = 4'he;
    wb(1'b1, REG_CTRL, 32'h1);
    bsel = 4'hf;
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, r);
    wb(1'b1, REG_CTRL, 32'h1);
    scmd(CMD_READ_STATUS1, 1'b0, 1'b1, 8'h01);
    wb(1'b1, REG_CTRL, 32'h0);
    scmd(CMD_QUAD_IO_READ, 1'b0, 1'b1, 8'hff);
    wrsr(8'hfc, 8'h02);
    scmd(CMD_READ_STATUS2, 1'b0, 1'b1, 8'h02);
    host.mode(1'b1);
    scmd(CMD_READ_STATUS2, 1'b0, 1'b1, 8'h02);
    host.mode(1'b0);
    scmd(CMD_READ_STATUS1, 1'b0, 1'b1, 8'hfc);
    chk("hold", 32'h0, {31'h0, hold_en | wp_en});
    qread(1'b1, 8'h10, 8'ha5);
    state(32'h3);
    qread(1'b0, 8'h20, 8'ha3);
    state(32'h3);
    qread(1'b0, 8'h30, 8'h00);
    state(32'h1);
    qread(1'b1, 8'h40, 8'ha5);
    host.frame(1'b1);
    host.idle(8, EXIT_NIB);
    host.frame(1'b0);
    state(32'h1);
    scmd(CMD_ENTER_FOUR_WIRE, 1'b0, 1'b0, 8'h0);
    state(32'h5);
    scmd(CMD_READ_STATUS2, 1'b1, 1'b1, 8'h02);
    scmd(CMD_EXIT_FOUR_WIRE, 1'b1, 1'b0, 8'h0);
    state(32'h1);
    scmd(CMD_ENTER_FOUR_WIRE, 1'b0, 1'b0, 8'h0);
    scmd(CMD_RESET_ENABLE, 1'b1, 1'b0, 8'h0);
    scmd(CMD_RESET, 1'b1, 1'b0, 8'h0);
    state(32'h1);
    host.frame(1'b1);
    host.put(CMD_READ_DISCOVERY, 1'b0);
    host.put(8'h00, 1'b0);
    host.put(8'h00, 1'b0);
    host.put(8'h9c, 1'b0);
    host.idle(8, 4'h0);
    host.get(b, 1'b0);
    chk("discovery", 32'he8, {24'h0, b});
    host.frame(1'b0);
    wrsr(8'h00, 8'h00);
    scmd(CMD_ENTER_FOUR_WIRE, 1'b0, 1'b0, 8'h0);
    state(32'h0);
    chk("hold", 32'h1, {31'h0, hold_en & wp_en});
    test_done();
  end
endmodule : tb
